/* File: common/sinc3_params.svh */
/*
 Timing counts, reset values and register offsets of the sinc3 decimator.
 Assumes inclusion by bare name from the package and from the design file.
*/
`ifndef SINC3_PARAMS_SVH
`define SINC3_PARAMS_SVH

`define MOD_RATE_HZ       32768
`define CLK_RATE_HZ       20000000
`define DEC_MULT          8
`define DEC_WORD_RESET    8'h45
`define DEC_WORD_MIN_OFF  8'h03
`define DEC_WORD_MIN_CHOP 8'h0d
`define STEP_SETTLE_CONV  3'h3
`define FREE_SETTLE_CONV  3'h4
`define STEP_PER_WORD_NS  244000
`define ADDR_DEC_WORD     4'h0
`define ADDR_CONTROL      4'h1
`define ADDR_STATUS       4'h2
`define ADDR_RESULT_LO    4'h3
`define ADDR_RESULT_MID   4'h4
`define ADDR_RESULT_HI    4'h5
`define CTRL_CHOP_OFF_BIT 0
`define CTRL_BUF_LO_BIT   1
`define CTRL_BUF_HI_BIT   2
`define CTRL_BURN_BIT     3
`define CTRL_SYNC_BIT     4
`define CTRL_CHAN_LSB     5
`define CTRL_RESET        8'h01
`define ACC_W             27

`endif

/* File: common/sinc3_pkg.sv */
/*
 Types of the sinc3 decimator: register bus carrier, result carrier, states.
 Assumes sinc3_params.svh on the include path.
*/
`include "sinc3_params.svh"

package sinc3_pkg;

	typedef logic [`ACC_W-1:0] acc_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_s;

	typedef struct packed {
		logic       unsettled;
		acc_t       data;
	} result_s;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_SETTLE = 2'b01,
		ST_RUN    = 2'b11
	} conv_state_e;

endpackage

/* File: rtl/sinc3_decimator.sv */
/*
 Sinc3 decimation filter of the primary converter, chop-disabled signal chain.
 Assumes a modulator bit and a one-cycle sample strobe synchronous to
 core_clk, and a register master that never asks for more than one strobe.
*/
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "sinc3_params.svh"

module sinc3_decimator (
	input  wire logic                 core_clk,
	input  wire logic                 arst_n,
	input  wire logic                 mod_bit,
	input  wire logic                 mod_strobe,
	input  wire logic                 unsync_step,
	input  wire logic                 calibrating,
	input  wire sinc3_pkg::reg_req_s  reg_req,
	output logic [7:0]                reg_rdata,
	output logic                      result_valid,
	input  wire logic                 result_ready,
	output sinc3_pkg::result_s        result,
	output logic                      burnout_enable,
	output logic                      overflow
);

	localparam int DEC_W = 11;
	// Wide arithmetic: the nanosecond product does not fit in 32 bits
	localparam longint CONV_NS_PER_WORD =
		longint'(`DEC_MULT) * 64'd1000000000 / `MOD_RATE_HZ;

	typedef struct packed {
		logic [7:0]             dec_word;
		logic [7:0]             control;
		logic [2:0]             settle_cnt;
		logic [2:0]             free_cnt;
		logic [DEC_W-1:0]       phase;
		sinc3_pkg::acc_t        int1;
		sinc3_pkg::acc_t        int2;
		sinc3_pkg::acc_t        int3;
		sinc3_pkg::acc_t        comb_d1;
		sinc3_pkg::acc_t        comb_d2;
		sinc3_pkg::acc_t        comb_d3;
		sinc3_pkg::conv_state_e state;
		sinc3_pkg::result_s     buf0;
		sinc3_pkg::result_s     buf1;
		logic [1:0]             count;
		logic                   ovf;
		logic [7:0]             rdata;
	} state_s;

	state_s st;
	state_s next_st;

	// Clamp to the lower bound of the active chop mode
	function automatic logic [7:0] eff_word(input logic [7:0] w,
		input logic chop_off);
		logic [7:0] lo;
		lo = chop_off ? `DEC_WORD_MIN_OFF : `DEC_WORD_MIN_CHOP;
		eff_word = (w < lo) ? lo : w;
	endfunction

	logic [7:0]            word_now;
	logic [DEC_W-1:0]      period;
	logic                  chop_off;
	logic                  buf_on;
	logic                  conv_done;
	logic                  restart;
	logic                  word_wr;
	sinc3_pkg::acc_t       bit_in;
	sinc3_pkg::acc_t       c1;
	sinc3_pkg::acc_t       c2;
	sinc3_pkg::acc_t       c3;
	logic                  push;
	logic                  pop;
	sinc3_pkg::result_s    new_res;

	always_comb begin
		chop_off = st.control[`CTRL_CHOP_OFF_BIT];
		buf_on   = st.control[`CTRL_BUF_LO_BIT] | st.control[`CTRL_BUF_HI_BIT];
		word_now = eff_word(st.dec_word, chop_off);
		period   = {word_now, 3'b000};
		bit_in   = {{(`ACC_W-1){1'b0}}, mod_bit};
		conv_done = mod_strobe && (st.phase == period - 11'h001);
		restart  = reg_req.wr && reg_req.addr == `ADDR_CONTROL &&
			(reg_req.wdata[`CTRL_SYNC_BIT] ||
			reg_req.wdata[7:`CTRL_CHAN_LSB] !=
			st.control[7:`CTRL_CHAN_LSB]);
		// A new word restarts the phase so a shorter period is never skipped
		word_wr  = reg_req.wr && reg_req.addr == `ADDR_DEC_WORD;
		c1 = st.int3 - st.comb_d1;
		c2 = c1 - st.comb_d2;
		c3 = c2 - st.comb_d3;
		new_res.data = c3;
		new_res.unsettled = (st.free_cnt != 3'h0);
		push = conv_done && st.state == sinc3_pkg::ST_RUN;
		pop  = (st.count != 2'h0) && result_ready;
	end

	assign result_valid   = st.count != 2'h0;
	assign result         = st.buf0;
	assign reg_rdata      = st.rdata;
	assign burnout_enable = st.control[`CTRL_BURN_BIT] & buf_on;
	assign overflow       = st.ovf;

	always_comb begin
		next_st = st;
		next_st.rdata = 8'h00;
		if (mod_strobe) begin
			next_st.int1 = st.int1 + bit_in;
			next_st.int2 = st.int2 + st.int1;
			next_st.int3 = st.int3 + st.int2;
			next_st.phase = conv_done ? 11'h000 : st.phase + 11'h001;
		end
		if (conv_done) begin
			next_st.comb_d1 = st.int3;
			next_st.comb_d2 = c1;
			next_st.comb_d3 = c2;
			if (st.free_cnt != 3'h0)
				next_st.free_cnt = st.free_cnt - 3'h1;
		end
		if (unsync_step)
			next_st.free_cnt = `FREE_SETTLE_CONV;
		case (st.state)
		sinc3_pkg::ST_IDLE: begin
			next_st.settle_cnt = `STEP_SETTLE_CONV;
			next_st.state = sinc3_pkg::ST_SETTLE;
		end
		sinc3_pkg::ST_SETTLE: begin
			if (conv_done) begin
				next_st.settle_cnt = st.settle_cnt - 3'h1;
				if (st.settle_cnt == 3'h1)
					next_st.state = sinc3_pkg::ST_RUN;
			end
		end
		sinc3_pkg::ST_RUN: begin
		end
		default: next_st.state = sinc3_pkg::ST_IDLE;
		endcase
		if (restart) begin
			next_st.state = sinc3_pkg::ST_SETTLE;
			next_st.settle_cnt = `STEP_SETTLE_CONV;
			next_st.phase = 11'h000;
		end
		// Two-entry buffer, buf0 is the head
		if (pop) begin
			next_st.buf0 = st.buf1;
			next_st.count = st.count - 2'h1;
		end
		if (push) begin
			if (st.count == 2'h2 && !pop) begin
				next_st.ovf = 1'b1;
			end else if (next_st.count == 2'h0) begin
				next_st.buf0 = new_res;
				next_st.count = 2'h1;
			end else begin
				next_st.buf1 = new_res;
				next_st.count = 2'h2;
			end
		end
		if (reg_req.wr) begin
			if (reg_req.addr == `ADDR_DEC_WORD) begin
				next_st.dec_word = reg_req.wdata;
				next_st.phase = 11'h000;
			end else if (reg_req.addr == `ADDR_CONTROL) begin
				next_st.control = reg_req.wdata;
				next_st.control[`CTRL_SYNC_BIT] = 1'b0;
			end else if (reg_req.addr == `ADDR_STATUS) begin
				if (reg_req.wdata[0] && !(push && st.count == 2'h2 && !pop))
					next_st.ovf = 1'b0;
			end
		end
		if (reg_req.rd) begin
			if (reg_req.addr == `ADDR_DEC_WORD) begin
				next_st.rdata = st.dec_word;
			end else if (reg_req.addr == `ADDR_CONTROL) begin
				next_st.rdata = st.control;
			end else if (reg_req.addr == `ADDR_STATUS) begin
				next_st.rdata = {3'h0, st.state == sinc3_pkg::ST_RUN,
					st.free_cnt == 3'h0, st.count, st.ovf};
			end else if (reg_req.addr == `ADDR_RESULT_LO) begin
				next_st.rdata = st.buf0.data[7:0];
			end else if (reg_req.addr == `ADDR_RESULT_MID) begin
				next_st.rdata = st.buf0.data[15:8];
			end else if (reg_req.addr == `ADDR_RESULT_HI) begin
				next_st.rdata = st.buf0.data[23:16];
			end else begin
				next_st.rdata = 8'h00;
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
			st.dec_word <= `DEC_WORD_RESET;
			st.control <= `CTRL_RESET;
			st.state <= sinc3_pkg::ST_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// Cycle counter of the current conversion in modulator strobes
	logic [DEC_W-1:0] strobes_seen;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			strobes_seen <= 11'h000;
		else if (conv_done || restart || word_wr)
			strobes_seen <= 11'h000;
		else if (mod_strobe)
			strobes_seen <= strobes_seen + 11'h001;
	end

	a_word_reset: assert property (@(posedge core_clk)
		$rose(arst_n) |-> st.dec_word == `DEC_WORD_RESET)
		else $error("decimation word reset value wrong");
	a_word_floor: assert property (@(posedge core_clk) disable iff (!arst_n)
		word_now >= (chop_off ? 8'h03 : 8'h0d))
		else $error("effective decimation word below floor");
	a_conv_length: assert property (@(posedge core_clk)
		disable iff (!arst_n)
		conv_done |-> strobes_seen == {word_now, 3'b000} - 11'h001)
		else $error("conversion length not eight times word");
	a_word_write: assert property (@(posedge core_clk) disable iff (!arst_n)
		reg_req.wr && reg_req.addr == `ADDR_DEC_WORD |=>
		st.dec_word == $past(reg_req.wdata))
		else $error("decimation word write lost");
	a_settle_hold: assert property (@(posedge core_clk)
		disable iff (!arst_n)
		restart |=> st.state == sinc3_pkg::ST_SETTLE &&
		st.settle_cnt == 3'h3)
		else $error("settling not restarted");
	a_no_push_settle: assert property (@(posedge core_clk)
		disable iff (!arst_n)
		st.state != sinc3_pkg::ST_RUN |-> !push)
		else $error("result pushed while settling");
	a_unsync_flag: assert property (@(posedge core_clk)
		disable iff (!arst_n)
		unsync_step |=> st.free_cnt == 3'h4)
		else $error("unsettled window not armed");
	a_burnout_gate: assert property (@(posedge core_clk)
		disable iff (!arst_n)
		burnout_enable |-> buf_on)
		else $error("burnout on without buffering");
	a_valid_push: assert property (@(posedge core_clk)
		disable iff (!arst_n)
		push && st.count == 2'h0 |=> result_valid)
		else $error("result not presented");
	a_ns_per_word: assert property (@(posedge core_clk)
		CONV_NS_PER_WORD / 1000 == `STEP_PER_WORD_NS / 1000)
		else $error("conversion step per word wrong");

	c_first_result: cover property (@(posedge core_clk) push);
	c_buffer_full: cover property (@(posedge core_clk) st.count == 2'h2);
	c_chan_change: cover property (@(posedge core_clk) restart);
	c_unsync: cover property (@(posedge core_clk) unsync_step);

endmodule

`default_nettype wire

/* File: verification/mod_stream_model.sv */
/*
 Behavioural modulator: one-bit stream beside a one-cycle sample strobe.
 Assumes the core_clk and arst_n of the converter block.
*/
`timescale 1ns/100ps
`default_nettype none
module mod_stream_model #(
	parameter int DIV = 4
) (
	input  wire logic core_clk,
	input  wire logic arst_n,
	input  wire logic level,
	output logic      mod_bit,
	output logic      mod_strobe
);
	int cnt;
	// Bit toggles between strobes so that nothing relies on a stale value
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= 0;
			mod_strobe <= 1'b0;
			mod_bit <= 1'b0;
		end else begin
			cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
			mod_strobe <= (cnt == DIV - 1);
			mod_bit <= (cnt == DIV - 1) ? level : ~mod_bit;
		end
	end
endmodule
`default_nettype wire

/* File: verification/sinc3_decimator_nochop_tb_top.sv */
/*
 Self-checking bench of the sinc3 decimator with the modulator model.
 Assumes sinc3_pkg compiled first and the register map of the hand-over.
*/
`timescale 1ns/100ps
`default_nettype none
module sinc3_decimator_nochop_tb_top;
	localparam int DIV = 4;
	logic                core_clk;
	logic                arst_n;
	logic                level;
	logic                mod_bit;
	logic                mod_strobe;
	logic                unsync_step;
	logic                calibrating;
	logic                result_valid;
	logic                result_ready;
	logic                burnout_enable;
	logic                overflow;
	logic [7:0]          reg_rdata;
	sinc3_pkg::reg_req_s reg_req;
	sinc3_pkg::result_s  result;
	sinc3_pkg::result_s  last;
	sinc3_pkg::acc_t     d;
	int                  err_total;
	int                  n_checks;
	int                  n;
	logic [7:0]          ctl [5] = '{8'h09, 8'h0b, 8'h0d, 8'h0f, 8'h07};
	logic [7:0]          rst_ctl [2] = '{8'h11, 8'h21};

	mod_stream_model #(.DIV(DIV)) model_u (.core_clk(core_clk),
		.arst_n(arst_n), .level(level), .mod_bit(mod_bit),
		.mod_strobe(mod_strobe));
	sinc3_decimator dut_u (.core_clk(core_clk), .arst_n(arst_n),
		.mod_bit(mod_bit), .mod_strobe(mod_strobe),
		.unsync_step(unsync_step), .calibrating(calibrating),
		.reg_req(reg_req), .reg_rdata(reg_rdata),
		.result_valid(result_valid), .result_ready(result_ready),
		.result(result), .burnout_enable(burnout_enable),
		.overflow(overflow));

	task automatic final_report();
		$display("Checks %0d, errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		reg_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		reg_req <= '0;
		@(posedge core_clk);
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] m,
		input logic [7:0] e);
		reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		reg_req <= '0;
		#1 chk(32'(reg_rdata & m), 32'(e));
		@(posedge core_clk);
	endtask

	// Counts strobes until the next word is taken from the buffer
	task automatic pop(output int s);
		s = 0;
		for (int i = 0; i < 20000; i++) begin
			@(posedge core_clk);
			#1;
			if (result_valid === 1'b1 && result_ready === 1'b1) begin
				last = result;
				return;
			end
			s += (mod_strobe === 1'b1);
		end
		chk(32'h0, 32'h1);
	endtask

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	initial begin
		repeat (100000) @(posedge core_clk);
		err_total++;
		final_report();
	end

	initial begin
		err_total = 0;
		n_checks = 0;
		arst_n = 1'b0;
		level = 1'b1;
		unsync_step = 1'b0;
		calibrating = 1'b0;
		result_ready = 1'b1;
		reg_req = '0;
		repeat (8) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		rd(4'h0, 8'hff, 8'h45);
		rd(4'h1, 8'hff, 8'h01);
		rd(4'hf, 8'hff, 8'h00);
		foreach (ctl[i]) begin
			wr(4'h1, ctl[i]);
			chk(32'(burnout_enable), 32'(ctl[i][3] & (ctl[i][1] | ctl[i][2])));
		end
		calibrating <= 1'b1;
		wr(4'h0, 8'hff);
		rd(4'h0, 8'hff, 8'hff);
		for (int w = 3; w < 5; w++) begin
			wr(4'h0, 8'(w));
			rd(4'h0, 8'hff, 8'(w));
			pop(n);
			pop(n);
			chk(32'(n), 32'(8 * w));
		end
		calibrating <= 1'b0;
		foreach (rst_ctl[i]) begin
			wr(4'h1, rst_ctl[i]);
			pop(n);
			chk(32'(n >= 95 && n <= 129), 32'h1);
			chk(32'(last.unsettled), 32'h0);
		end
		unsync_step <= 1'b1;
		@(posedge core_clk);
		unsync_step <= 1'b0;
		for (int k = 0; k < 5; k++) begin
			pop(n);
			chk(32'(last.unsettled), 32'(k < 4));
		end
		d = last.data;
		pop(n);
		chk(32'(last.data), 32'(d));
		chk(32'(last.data), 32'h8000);
		result_ready <= 1'b0;
		repeat (3 * 32 * DIV + 40) @(posedge core_clk);
		#1 chk(32'(result_valid), 32'h1);
		rd(4'h2, 8'h07, 8'h05);
		chk(32'(overflow), 32'h1);
		result_ready <= 1'b1;
		repeat (3) @(posedge core_clk);
		#1 chk(32'(result_valid), 32'h0);
		wr(4'h2, 8'h01);
		rd(4'h2, 8'h07, 8'h00);
		final_report();
	end
endmodule
`default_nettype wire
